// [src/bpsw_device.sv]
// Purpose: sleep/wake and FET gating logic of the protection device
// Assumes: comparator levels arrive asynchronously; frame data are stable
//          while the frame-done flag is high
// Notes:   FET drives are active low (1 = FET off)
`timescale 1ns/1ns
module bpsw_device
  import bpsw_pkg::*;
#(
  parameter int          N_CELLS  = bpsw_pkg::CELLS,
  parameter int unsigned OD_DELAY = bpsw_pkg::OD_DELAY_CYC,
  parameter int unsigned WAKE_RST = bpsw_pkg::WAKE_RST_CYC
) (
  // clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               sys_rst_i,
  // serial host port
  bpsw_link_if.dev                link,
  // analog comparator levels
  input  wire logic               wake_above_i,
  input  wire logic [N_CELLS-1:0] cell_below_od_i,
  input  wire logic [N_CELLS-1:0] cell_above_ce_i,
  // FET drives and regulator
  output logic                    charge_fet_drive_o,
  output logic                    discharge_fet_drive_o,
  output logic                    regulated_supply_output_o,
  // comparator selection and status
  output logic [1:0]              charge_enable_threshold_sel_o,
  output logic                    asleep_o,
  output logic                    od_protect_o,
  output logic                    ce_blocked_o,
  output logic                    wake_reset_busy_o
);
  import bpsw_pkg::*;

  localparam int SW = 2 * N_CELLS + 2;

  // link side, runs on the host's clock only during a frame
  typedef struct packed {
    logic [FRAME_BITS-1:0] sh;
    logic [4:0]            cnt;
    logic                  done;
  } bpsw_link_s;

  typedef struct packed {
    bpsw_core_state_e st;
    logic [7:0]       ctrl;
    logic [7:0]       cfg;
    logic [31:0]      od_cnt;
    logic [31:0]      rst_cnt;
    logic             od_prot;
    logic             frame_seen;
    logic             chg_drv;
    logic             dsg_drv;
    logic             reg_en;
    logic             asleep;
    logic             blocked;
    logic             busy;
  } bpsw_core_s;

  bpsw_link_s lk_reg;
  bpsw_link_s lk_next;
  bpsw_core_s c_reg;
  bpsw_core_s c_next;

  logic                 link_rst;
  logic [SW-1:0]        sync_q;
  logic                 wake_s;
  logic                 fdone_s;
  logic [N_CELLS-1:0]   od_s;
  logic [N_CELLS-1:0]   ce_s;

  // select high clears the frame logic so a broken frame cannot linger
  assign link_rst = sys_rst_i | link.cs_n;

  always_comb begin
    lk_next = lk_reg;
    if (!lk_reg.done) begin
      lk_next.sh  = {lk_reg.sh[FRAME_BITS-2:0], link.mosi};
      lk_next.cnt = lk_reg.cnt + 5'h01;
      if (lk_reg.cnt == 5'(FRAME_BITS - 1)) begin
        lk_next.done = 1'b1;
      end
    end
  end

  always_ff @(posedge link.sclk or posedge link_rst) begin
    if (link_rst) begin
      lk_reg <= '0;
    end else begin
      lk_reg <= lk_next;
    end
  end

  bpsw_sync3 #(
    .W (SW)
  ) u_sync (
    .clk_i (ref_clk_i),
    .rst_i (sys_rst_i),
    .d_i   ({lk_reg.done, wake_above_i, cell_below_od_i, cell_above_ce_i}),
    .q_o   (sync_q)
  );

  assign ce_s    = sync_q[N_CELLS-1:0];
  assign od_s    = sync_q[2*N_CELLS-1:N_CELLS];
  assign wake_s  = sync_q[2*N_CELLS];
  assign fdone_s = sync_q[2*N_CELLS+1];

  always_comb begin
    logic       ce_ok;
    logic       frame_new;
    logic       fet_en;
    logic [7:0] instr;
    logic [7:0] data;
    ce_ok     = 1'b0;
    frame_new = 1'b0;
    fet_en    = 1'b0;
    instr     = lk_reg.sh[15:8];
    data      = lk_reg.sh[7:0];
    c_next    = c_reg;

    // disabled check passes every cell, as if the threshold were zero
    ce_ok     = (&ce_s) | c_reg.cfg[CFG_CEDIS_BIT];
    frame_new = fdone_s & ~c_reg.frame_seen;
    c_next.frame_seen = fdone_s;

    // port is dead in sleep; accepted again once awake
    if (frame_new && c_reg.st != BPSW_ST_SLEEP) begin
      if (instr == INSTR_CFG_WR) begin
        c_next.cfg = data;
      end else if (instr == INSTR_CTRL_WR) begin
        if (c_reg.st == BPSW_ST_RUN) begin
          c_next.ctrl = data;
        end else begin
          // FET bits held off until the wake sequence completes
          c_next.ctrl[CTRL_SLP_BIT] = data[CTRL_SLP_BIT];
        end
      end
    end

    case (c_reg.st)
      BPSW_ST_RUN: begin
        if (|od_s) begin
          if (c_reg.od_cnt == 32'(OD_DELAY - 1)) begin
            c_next.od_cnt                = '0;
            c_next.od_prot               = 1'b1;
            c_next.ctrl[CTRL_CHG_BIT]    = 1'b0;
            c_next.ctrl[CTRL_DSG_BIT]    = 1'b0;
          end else begin
            c_next.od_cnt = c_reg.od_cnt + 32'h1;
          end
        end else begin
          c_next.od_cnt = '0;
        end
      end
      BPSW_ST_SLEEP: begin
        if (wake_s) begin
          c_next.st      = BPSW_ST_CE_WAIT;
          c_next.od_prot = 1'b0;
        end
      end
      BPSW_ST_CE_WAIT: begin
        if (ce_ok) begin
          c_next.st      = BPSW_ST_WAKE_RST;
          c_next.rst_cnt = '0;
        end
      end
      BPSW_ST_WAKE_RST: begin
        if (c_reg.rst_cnt == 32'(WAKE_RST - 1)) begin
          c_next.st = BPSW_ST_RUN;
        end else begin
          c_next.rst_cnt = c_reg.rst_cnt + 32'h1;
        end
      end
      default: begin
        c_next.st = BPSW_ST_RUN;
      end
    endcase

    // pending requests wait while the supply is above the wake threshold
    if (c_reg.st != BPSW_ST_SLEEP && !wake_s &&
        (c_next.od_prot || c_next.ctrl[CTRL_SLP_BIT])) begin
      c_next.st                 = BPSW_ST_SLEEP;
      c_next.od_cnt             = '0;
      c_next.ctrl[CTRL_SLP_BIT] = 1'b0;
      c_next.ctrl[CTRL_CHG_BIT] = 1'b0;
      c_next.ctrl[CTRL_DSG_BIT] = 1'b0;
    end

    // drives follow the control bits only when awake and cells pass
    fet_en = (c_next.st == BPSW_ST_RUN) && ce_ok;
    c_next.chg_drv = ~(fet_en & c_next.ctrl[CTRL_CHG_BIT]);
    c_next.dsg_drv = ~(fet_en & c_next.ctrl[CTRL_DSG_BIT]);
    c_next.reg_en  = (c_next.st != BPSW_ST_SLEEP);
    c_next.asleep  = (c_next.st == BPSW_ST_SLEEP);
    c_next.blocked = ~ce_ok;
    c_next.busy    = (c_next.st == BPSW_ST_WAKE_RST);
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      c_reg            <= '0;
      c_reg.st         <= BPSW_ST_RUN;
      c_reg.ctrl       <= CTRL_RST;
      c_reg.cfg        <= CFG_RST;
      c_reg.chg_drv    <= 1'b1;
      c_reg.dsg_drv    <= 1'b1;
      c_reg.reg_en     <= 1'b1;
    end else begin
      c_reg <= c_next;
    end
  end

  assign charge_fet_drive_o            = c_reg.chg_drv;
  assign discharge_fet_drive_o         = c_reg.dsg_drv;
  assign regulated_supply_output_o     = c_reg.reg_en;
  assign charge_enable_threshold_sel_o = {c_reg.cfg[CFG_CESEL_HI], c_reg.cfg[CFG_CESEL_LO]};
  assign asleep_o                      = c_reg.asleep;
  assign od_protect_o                  = c_reg.od_prot;
  assign ce_blocked_o                  = c_reg.blocked;
  assign wake_reset_busy_o             = c_reg.busy;
endmodule

// [src/bpsw_pkg.sv]
// Purpose: shared constants and types for the battery pack sleep/wake control
// Assumes: 250 MHz reference clock, three cells, write-only serial host port
// Notes:   frame = 8-bit instruction then 8-bit data, msb first
package bpsw_pkg;

  localparam int CELLS          = 3;
  localparam int CLK_MHZ        = 250;
  localparam int T_UV_MS        = 1000;
  localparam int T_OV_MS        = 1000;
  localparam int T_RST_EXTRA_MS = 200;
  localparam int T_LONGER_MS    = (T_OV_MS > T_UV_MS) ? T_OV_MS : T_UV_MS;

  localparam int unsigned OD_DELAY_CYC = T_UV_MS * CLK_MHZ * 1000;
  localparam int unsigned WAKE_RST_CYC = (T_LONGER_MS + T_RST_EXTRA_MS) * CLK_MHZ * 1000;

  localparam int FRAME_BITS = 16;

  localparam logic [7:0] INSTR_CTRL_WR = 8'h01;
  localparam logic [7:0] INSTR_CFG_WR  = 8'h02;

  localparam int CTRL_CHG_BIT  = 0;
  localparam int CTRL_DSG_BIT  = 1;
  localparam int CTRL_SLP_BIT  = 2;
  localparam int CFG_CESEL_LO  = 0;
  localparam int CFG_CESEL_HI  = 1;
  localparam int CFG_CEDIS_BIT = 2;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CFG_RST  = 8'h00;

  localparam int SCLK_HALF_CYC = 2;
  localparam int CS_HOLD_CYC   = 8;
  localparam int CS_GAP_CYC    = 8;

  typedef enum logic [1:0] {
    BPSW_ST_RUN,
    BPSW_ST_SLEEP,
    BPSW_ST_CE_WAIT,
    BPSW_ST_WAKE_RST
  } bpsw_core_state_e;

endpackage

// [src/bpsw_link_if.sv]
// Purpose: serial host port between host controller and protection device
// Assumes: host makes the link clock; device samples data on its rising edge
// Notes:   link clock runs only while the select is low
`timescale 1ns/1ns
interface bpsw_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;

  modport host (output sclk, output cs_n, output mosi);
  modport dev  (input sclk, input cs_n, input mosi);
endinterface

// [src/bpsw_sync3.sv]
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs come from another clock domain or from pins
// Notes:   a change is taken once the second and third stages agree
`timescale 1ns/1ns
module bpsw_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } bpsw_sync_s;

  bpsw_sync_s r_reg;
  bpsw_sync_s r_next;

  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d_i;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (r_reg.s2[i] == r_reg.s3[i]) begin
        r_next.q[i] = r_reg.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q_o = r_reg.q;
endmodule

// [src/bpsw_host.sv]
// Purpose: host end of the serial port, sends one write frame per request
// Assumes: link clock made here by dividing the reference clock
// Notes:   data change while the link clock is low
`timescale 1ns/1ns
module bpsw_host
  import bpsw_pkg::*;
#(
  parameter int HALF_CYC = bpsw_pkg::SCLK_HALF_CYC,
  parameter int HOLD_CYC = bpsw_pkg::CS_HOLD_CYC,
  parameter int GAP_CYC  = bpsw_pkg::CS_GAP_CYC
) (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  // serial host port
  bpsw_link_if.host       link,
  // user request
  input  wire logic       req_valid_i,
  input  wire logic [7:0] req_instr_i,
  input  wire logic [7:0] req_data_i,
  input  wire logic       fet_write_block_i,
  output logic            req_ready_o,
  output logic            done_o
);
  import bpsw_pkg::*;

  typedef enum logic [1:0] {
    BPSW_H_IDLE,
    BPSW_H_SHIFT,
    BPSW_H_HOLD,
    BPSW_H_GAP
  } bpsw_host_state_e;

  typedef struct packed {
    bpsw_host_state_e      st;
    logic [7:0]            cnt;
    logic [4:0]            bitn;
    logic [FRAME_BITS-1:0] word;
    logic                  sclk;
    logic                  cs_n;
    logic                  mosi;
    logic                  ready;
    logic                  done;
  } bpsw_host_s;

  bpsw_host_s h_reg;
  bpsw_host_s h_next;

  always_comb begin
    logic take;
    take        = 1'b0;
    h_next      = h_reg;
    h_next.done = 1'b0;
    case (h_reg.st)
      BPSW_H_IDLE: begin
        // control writes wait while the wake reset period runs
        take = req_valid_i && h_reg.ready &&
               !(fet_write_block_i && req_instr_i == INSTR_CTRL_WR);
        if (take) begin
          h_next.word  = {req_instr_i, req_data_i};
          h_next.mosi  = req_instr_i[7];
          h_next.cs_n  = 1'b0;
          h_next.bitn  = '0;
          h_next.cnt   = '0;
          h_next.ready = 1'b0;
          h_next.st    = BPSW_H_SHIFT;
        end
      end
      BPSW_H_SHIFT: begin
        if (h_reg.cnt == 8'(HALF_CYC - 1)) begin
          h_next.cnt = '0;
          if (!h_reg.sclk) begin
            h_next.sclk = 1'b1;
          end else begin
            h_next.sclk = 1'b0;
            if (h_reg.bitn == 5'(FRAME_BITS - 1)) begin
              h_next.st = BPSW_H_HOLD;
            end else begin
              h_next.bitn = h_reg.bitn + 5'h01;
              h_next.word = {h_reg.word[FRAME_BITS-2:0], 1'b0};
              h_next.mosi = h_reg.word[FRAME_BITS-2];
            end
          end
        end else begin
          h_next.cnt = h_reg.cnt + 8'h01;
        end
      end
      BPSW_H_HOLD: begin
        if (h_reg.cnt == 8'(HOLD_CYC - 1)) begin
          h_next.cnt  = '0;
          h_next.cs_n = 1'b1;
          h_next.mosi = 1'b0;
          h_next.done = 1'b1;
          h_next.st   = BPSW_H_GAP;
        end else begin
          h_next.cnt = h_reg.cnt + 8'h01;
        end
      end
      BPSW_H_GAP: begin
        if (h_reg.cnt == 8'(GAP_CYC - 1)) begin
          h_next.cnt   = '0;
          h_next.ready = 1'b1;
          h_next.st    = BPSW_H_IDLE;
        end else begin
          h_next.cnt = h_reg.cnt + 8'h01;
        end
      end
      default: begin
        h_next.st = BPSW_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      h_reg       <= '0;
      h_reg.st    <= BPSW_H_IDLE;
      h_reg.cs_n  <= 1'b1;
      h_reg.ready <= 1'b1;
    end else begin
      h_reg <= h_next;
    end
  end

  assign link.sclk   = h_reg.sclk;
  assign link.cs_n   = h_reg.cs_n;
  assign link.mosi   = h_reg.mosi;
  assign req_ready_o = h_reg.ready;
  assign done_o      = h_reg.done;
endmodule

// [verif/bpsw_link_properties.sv]
// Purpose: concurrent checks on the serial link and the device outputs
// Assumes: default host timing, 16-bit frames
// Notes:   instantiated beside the link interface, no bind
`timescale 1ns/1ns
module bpsw_link_properties (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // link wires
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  // device outputs
  input wire logic charge_fet_drive_o,
  input wire logic discharge_fet_drive_o,
  input wire logic regulated_supply_output_o,
  input wire logic asleep_o,
  input wire logic od_protect_o,
  input wire logic ce_blocked_o,
  input wire logic wake_reset_busy_o
);
  logic [4:0] rise_cnt;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // counts link clock rises inside one frame
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) rise_cnt <= 5'h00;
    else if (cs_n) rise_cnt <= 5'h00;
    else if ($rose(sclk)) rise_cnt <= rise_cnt + 5'h01;
  end
  sequence frame_open;
    $fell(cs_n) ##1 !sclk;
  endsequence
  sequence frame_close;
    ##71 $rose(cs_n);
  endsequence
  link_idle_a: assert property (cs_n |-> !sclk)
    else $error("link clock moves outside a frame");
  mosi_hold_a: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("data changed at the link clock rise");
  frame_len_a: assert property (frame_open |-> frame_close)
    else $error("frame select length wrong");
  frame_bits_a: assert property ($rose(cs_n) |-> rise_cnt == 5'h10)
    else $error("frame does not carry 16 bits");
  sleep_off_a: assert property (
    asleep_o |-> charge_fet_drive_o && discharge_fet_drive_o && !regulated_supply_output_o)
    else $error("drives or regulator on while asleep");
  ce_hold_a: assert property (
    ce_blocked_o |-> charge_fet_drive_o && discharge_fet_drive_o)
    else $error("fet on while cells fail the check");
  wake_rst_a: assert property (
    wake_reset_busy_o |-> charge_fet_drive_o && discharge_fet_drive_o)
    else $error("fet on during wake reset");
  od_off_a: assert property (
    $rose(od_protect_o) |-> charge_fet_drive_o && discharge_fet_drive_o)
    else $error("fet on at protection entry");
  wake_reg_a: assert property ($fell(asleep_o) |-> regulated_supply_output_o)
    else $error("regulator off after wake");
endmodule

// [verif/tb_battery_pack_sleep_wake_control.sv]
// Purpose: host and device joined over the link, driven from both user sides
// Assumes: shortened protection and wake reset delays
// Notes:   expectations follow the fixed host frame timing
`timescale 1ns/1ns
module tb_battery_pack_sleep_wake_control;
  import bpsw_pkg::*;
  logic       ref_clk_i  = 1'b0;
  logic       sys_rst_i  = 1'b1;
  logic       req_valid  = 1'b0;
  logic [7:0] req_instr  = 8'h00;
  logic [7:0] req_data   = 8'h00;
  logic       wake_above = 1'b0;
  logic [2:0] cell_below = 3'h0;
  logic [2:0] cell_above = 3'h0;
  logic       chg, dsg, reg_on, asleep, od, ceb, wrb, ready, done;
  logic [1:0] sel;
  int         n_mismatch = 0;
  int         tests_run  = 0;
  bpsw_link_if bpsw_link_if_i ();
  bpsw_host bpsw_host_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .link(bpsw_link_if_i), .req_valid_i(req_valid), .req_instr_i(req_instr),
    .req_data_i(req_data), .fet_write_block_i(wrb), .req_ready_o(ready), .done_o(done));
  bpsw_device #(.OD_DELAY(20), .WAKE_RST(30)) bpsw_device_i (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .link(bpsw_link_if_i), .wake_above_i(wake_above),
    .cell_below_od_i(cell_below), .cell_above_ce_i(cell_above),
    .charge_fet_drive_o(chg), .discharge_fet_drive_o(dsg),
    .regulated_supply_output_o(reg_on), .charge_enable_threshold_sel_o(sel),
    .asleep_o(asleep), .od_protect_o(od), .ce_blocked_o(ceb), .wake_reset_busy_o(wrb));
  bpsw_link_properties bpsw_link_properties_i (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .sclk(bpsw_link_if_i.sclk), .cs_n(bpsw_link_if_i.cs_n),
    .mosi(bpsw_link_if_i.mosi), .charge_fet_drive_o(chg), .discharge_fet_drive_o(dsg),
    .regulated_supply_output_o(reg_on), .asleep_o(asleep), .od_protect_o(od),
    .ce_blocked_o(ceb), .wake_reset_busy_o(wrb));
  always #2 ref_clk_i = ~ref_clk_i;
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic fets(input logic [1:0] exp);
    chk("fet drives", {6'h00, chg, dsg}, {6'h00, exp});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // one write frame; holds the request until the host takes it
  task automatic send(input logic [7:0] ins, input logic [7:0] dat);
    int k;
    @(posedge ref_clk_i);
    req_valid <= 1'b1;
    req_instr <= ins;
    req_data  <= dat;
    k = 0;
    do begin
      step(1);
      k++;
    end while (ready !== 1'b0 && k < 400);
    @(posedge ref_clk_i);
    req_valid <= 1'b0;
    do begin
      step(1);
      k++;
    end while (done !== 1'b1 && k < 800);
    chk("frame sent", {7'h00, done}, 8'h01);
    step(16);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    step(8);
    chk("reset outputs", {3'h0, chg, dsg, reg_on, asleep, od}, 8'h1C);
    for (int i = 0; i < 4; i++) begin
      send(INSTR_CFG_WR, 8'h04 | 8'(i));
      chk("threshold sel", {6'h00, sel}, 8'(i));
    end
    fets(2'b11);
    send(INSTR_CTRL_WR, 8'h01);
    fets(2'b01);
    send(INSTR_CTRL_WR, 8'h03);
    fets(2'b00);
    $display("test fet control done");
    send(INSTR_CFG_WR, 8'h00);
    fets(2'b11);
    chk("ce blocked", {7'h00, ceb}, 8'h01);
    send(INSTR_CFG_WR, 8'h04);
    fets(2'b00);
    $display("test charge check done");
    @(posedge ref_clk_i);
    wake_above <= 1'b1;
    step(8);
    send(INSTR_CTRL_WR, 8'h07);
    chk("sleep refused", {7'h00, asleep}, 8'h00);
    @(posedge ref_clk_i);
    wake_above <= 1'b0;
    step(12);
    chk("asleep", {5'h00, asleep, reg_on, chg}, 8'h05);
    send(INSTR_CTRL_WR, 8'h03);
    fets(2'b11);
    @(posedge ref_clk_i);
    wake_above <= 1'b1;
    step(10);
    chk("awake", {5'h00, asleep, reg_on, wrb}, 8'h03);
    fets(2'b11);
    // a control write offered during the wake reset must wait
    @(posedge ref_clk_i);
    req_valid <= 1'b1;
    req_instr <= INSTR_CTRL_WR;
    req_data  <= 8'h03;
    step(4);
    chk("write held off", {6'h00, ready, bpsw_link_if_i.cs_n}, 8'h03);
    send(INSTR_CTRL_WR, 8'h03);
    fets(2'b00);
    $display("test sleep done");
    send(INSTR_CFG_WR, 8'h00);
    @(posedge ref_clk_i);
    wake_above <= 1'b0;
    cell_below <= 3'h2;
    step(12);
    chk("od early", {6'h00, od, asleep}, 8'h00);
    step(30);
    chk("od sleep", {3'h0, od, asleep, chg, dsg, reg_on}, 8'h1E);
    @(posedge ref_clk_i);
    cell_below <= 3'h0;
    wake_above <= 1'b1;
    step(50);
    chk("ce wait", {5'h00, asleep, ceb, wrb}, 8'h02);
    @(posedge ref_clk_i);
    cell_above <= 3'h7;
    step(12);
    chk("ce pass", {7'h00, wrb}, 8'h01);
    step(40);
    $display("test over-discharge done");
    test_done;
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    test_done;
  end
endmodule
